// ==== bbmdp_pkg.sv ====
package bbmdp_pkg;

  // ****************************************
  // widths and timing
  // ****************************************
  localparam int BYTE_W = 8;
  localparam int CNT_W = 16;
  localparam int SYS_CLK_MHZ = 125;
  localparam int BIT_CLK_NS = 160;
  localparam int BIT_HALF_CYC = (BIT_CLK_NS * SYS_CLK_MHZ) / 2000;
  localparam int RAMP_NS = 2000;
  localparam int RAMP_CYC = (RAMP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int FIFO_DEPTH = 4;

  // ****************************************
  // synchroniser lanes
  // ****************************************
  localparam int SY_TRANSMIT_POWER_ENABLE = 0;
  localparam int SY_RECEIVE_POWER_ENABLE = 1;
  localparam int SY_TXD = 2;
  localparam int SY_RST = 3;
  localparam int SY_W = 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_SEND = 2'h1,
    TX_RAMP = 2'h3
  } bbmdp_tx_t;

  typedef struct packed {
    logic last;
    logic [BYTE_W-1:0] data;
  } bbmdp_rxw_t;

endpackage

// ==== bbmdp_fifo.sv ====
`timescale 1ns/10ps
module bbmdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  function automatic logic [AW-1:0] nxt_ptr(input logic [AW-1:0] p);
    nxt_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // honest full and empty from the fill count
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];

  // storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= nxt_ptr(wr_r);
      if (pop) rd_r <= nxt_ptr(rd_r);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== bbmdp_port.sv ====
`timescale 1ns/10ps
// Behaviour
// R1: controller drops transmit power enable before raising it for a new packet
// R2: keep modulating outputs a while after last transmit chip for ramp-down
// R3: start new acquisition search after last received packet bit
// R4: chip reset pin at 1 holds reset, at 0 normal operation
// R5: transmit power enable rising edge makes transmitter active
// R6: transmit power enable falling edge ends the transmission
// R7: receive power enable high keeps receiver and channel assessment running
// R8: channel clear flag high reports a clear channel
// R9: gain select high asks high gain, low asks low gain
// R10: transmit ready asserted when transmit data can be accepted
// R11: receive ready asserted when received data is ready to deliver
// R12: one generated bit clock times both transmit and receive data
// R13: controller sends transmit data serially on one input
// R14: received data leaves serially on the receive output
// R15: system supplies the master clock all internal clocks derive from
// R16: antenna choose output selects antenna for diversity
// R17: transmit data sampled with the self-generated bit clock
// R18: transmit has priority when both power enables are high
// R19: gain select forced low while transmit power enable is high
// R20: complementary antenna and gain outputs always inverse of true ones
module bbmdp_port #(
  parameter int HALF_CYC = bbmdp_pkg::BIT_HALF_CYC,
  parameter int RAMP_CYC = bbmdp_pkg::RAMP_CYC,
  parameter int DEPTH = bbmdp_pkg::FIFO_DEPTH
) (
  // system clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // pins from the controller
  input wire logic TRANSMIT_POWER_ENABLE_IN,
  input wire logic RECEIVE_POWER_ENABLE_IN,
  input wire logic TRANSMIT_SERIAL_IN,
  input wire logic CHIP_RESET_IN,
  // pins to the controller
  output logic PORT_BIT_CLOCK,
  output logic TRANSMIT_READY_OUT,
  output logic RECEIVE_READY_OUT,
  output logic RECEIVE_SERIAL_OUT,
  output logic CHANNEL_CLEAR_FLAG,
  output logic AMP_GAIN_SELECT_OUT,
  output logic AMP_GAIN_SELECT_N,
  output logic ANTENNA_CHOOSE,
  output logic ANTENNA_CHOOSE_N,
  // modulator side
  output logic TX_BYTE_VALID,
  input wire logic TX_BYTE_READY,
  output logic [bbmdp_pkg::BYTE_W-1:0] TX_BYTE,
  output logic MOD_RUN,
  output logic TX_DONE,
  // demodulator side
  input wire logic RX_WORD_VALID,
  output logic RX_WORD_READY,
  input wire bbmdp_pkg::bbmdp_rxw_t RX_WORD,
  input wire logic CHAN_CLEAR_IN,
  input wire logic HIGH_GAIN_IN,
  input wire logic ANT_ALT_IN,
  output logic RX_ENABLE,
  output logic ACQ_RESTART
);
  localparam int BW = bbmdp_pkg::BYTE_W;
  localparam int CW = bbmdp_pkg::CNT_W;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [bbmdp_pkg::SY_W-1:0] sy1_r;
  logic [bbmdp_pkg::SY_W-1:0] sy2_r;
  logic [bbmdp_pkg::SY_W-1:0] sy3_r;

  // two flops per pin, third only for edge finding
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy3_r <= '0;
    end else begin
      sy1_r <= {CHIP_RESET_IN, TRANSMIT_SERIAL_IN, RECEIVE_POWER_ENABLE_IN,
                TRANSMIT_POWER_ENABLE_IN};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  // decoded pin levels and edges
  wire soft_rst = sy2_r[bbmdp_pkg::SY_RST]; // R4
  wire transmit_power_enable = sy2_r[bbmdp_pkg::SY_TRANSMIT_POWER_ENABLE];
  wire receive_power_enable = sy2_r[bbmdp_pkg::SY_RECEIVE_POWER_ENABLE];
  wire txd = sy2_r[bbmdp_pkg::SY_TXD];
  wire transmit_power_enable_rise = transmit_power_enable && !sy3_r[bbmdp_pkg::SY_TRANSMIT_POWER_ENABLE]; // R1 R5
  wire transmit_power_enable_fall = !transmit_power_enable && sy3_r[bbmdp_pkg::SY_TRANSMIT_POWER_ENABLE]; // R6
  wire rx_on = receive_power_enable && !transmit_power_enable; // R7 R18

  // ****************************************
  // bit clock divider
  // ****************************************
  bbmdp_pkg::bbmdp_tx_t st_r;
  bbmdp_pkg::bbmdp_tx_t st_nxt;
  logic [CW-1:0] div_r;
  logic bclk_r;
  logic rx_busy_r;
  wire clk_run = (st_r == bbmdp_pkg::TX_SEND) || rx_busy_r;
  wire div_end = (div_r == CW'(HALF_CYC - 1));
  wire bit_rise = clk_run && div_end && !bclk_r;
  wire bit_fall = div_end && bclk_r;

  // one clock for both directions, parked low when idle
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      div_r <= '0;
      bclk_r <= 1'b0;
    end else if (soft_rst || (!clk_run && !bclk_r)) begin
      div_r <= '0;
      bclk_r <= 1'b0;
    end else if (div_end) begin
      div_r <= '0;
      bclk_r <= !bclk_r; // R12
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // ****************************************
  // transmit state machine
  // ****************************************
  logic [CW-1:0] ramp_r;
  wire ramp_end = (ramp_r == CW'(RAMP_CYC - 1));

  // idle, sending, ramp-down tail
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      bbmdp_pkg::TX_IDLE: begin
        if (transmit_power_enable_rise) st_nxt = bbmdp_pkg::TX_SEND; // R5
      end
      bbmdp_pkg::TX_SEND: begin
        if (transmit_power_enable_fall) st_nxt = bbmdp_pkg::TX_RAMP; // R6
      end
      bbmdp_pkg::TX_RAMP: begin
        if (ramp_end) st_nxt = bbmdp_pkg::TX_IDLE; // R2
      end
      default: begin
        st_nxt = bbmdp_pkg::TX_IDLE;
      end
    endcase
  end

  // state and tail counter
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= bbmdp_pkg::TX_IDLE;
      ramp_r <= '0;
    end else if (soft_rst) begin
      st_r <= bbmdp_pkg::TX_IDLE;
      ramp_r <= '0;
    end else begin
      st_r <= st_nxt;
      ramp_r <= (st_r == bbmdp_pkg::TX_RAMP) ? ramp_r + 1'b1 : '0;
    end
  end

  // ****************************************
  // transmit deserialiser and buffer
  // ****************************************
  logic [BW-1:0] tsh_r;
  logic [3:0] tcnt_r;
  logic tpush_r;
  logic [BW-1:0] tbyte_r;
  logic tf_in_ready;
  logic tf_out_valid;
  logic [BW-1:0] tf_out_data;
  wire sending = (st_r == bbmdp_pkg::TX_SEND);
  wire take_bit = sending && bit_rise && TRANSMIT_READY_OUT; // R17
  wire byte_full = (tcnt_r == 4'(BW - 1));
  wire tf_pop = !TX_BYTE_VALID; // output register empty, pull the next byte
  wire tx_load = tf_pop && tf_out_valid;

  // msb first shift, byte handed on when eight bits are in
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      tsh_r <= '0;
      tcnt_r <= '0;
      tpush_r <= 1'b0;
      tbyte_r <= '0;
    end else if (soft_rst || !sending) begin
      tsh_r <= '0;
      tcnt_r <= '0; // partial byte at end is dropped
      tpush_r <= 1'b0;
    end else begin
      if (tpush_r && tf_in_ready) tpush_r <= 1'b0;
      if (take_bit) begin
        tsh_r <= {tsh_r[BW-2:0], txd}; // R13
        tcnt_r <= byte_full ? '0 : tcnt_r + 1'b1;
        if (byte_full) begin
          tbyte_r <= {tsh_r[BW-2:0], txd};
          tpush_r <= 1'b1;
        end
      end
    end
  end

  bbmdp_fifo #(
    .WIDTH(BW),
    .DEPTH(DEPTH)
  ) u_tx_fifo (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .flush(soft_rst),
    .in_valid(tpush_r),
    .in_ready(tf_in_ready),
    .in_data(tbyte_r),
    .out_valid(tf_out_valid),
    .out_ready(tf_pop),
    .out_data(tf_out_data)
  );

  // ****************************************
  // receive serialiser
  // ****************************************
  logic [BW-1:0] rsh_r;
  logic [3:0] rcnt_r;
  logic rlast_r;
  logic rload_r;
  wire rx_take = RX_WORD_VALID && RX_WORD_READY;
  wire rbit_done = rx_busy_r && bit_fall;
  wire rbyte_end = rbit_done && (rcnt_r == 4'(BW - 1));

  // load a word, shift msb first on falling bit clock edges
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rsh_r <= '0;
      rcnt_r <= '0;
      rlast_r <= 1'b0;
      rx_busy_r <= 1'b0;
      rload_r <= 1'b0;
      RECEIVE_SERIAL_OUT <= 1'b0;
    end else if (soft_rst || !rx_on) begin
      rcnt_r <= '0;
      rx_busy_r <= 1'b0;
      rload_r <= 1'b0;
      RECEIVE_SERIAL_OUT <= 1'b0;
    end else if (rx_take) begin
      rsh_r <= {RX_WORD.data[BW-2:0], 1'b0};
      rlast_r <= RX_WORD.last;
      rcnt_r <= '0;
      rx_busy_r <= 1'b1;
      rload_r <= 1'b0;
      RECEIVE_SERIAL_OUT <= RX_WORD.data[BW-1]; // R14
    end else begin
      rload_r <= !rx_busy_r && !rload_r;
      if (rbit_done) begin
        rsh_r <= {rsh_r[BW-2:0], 1'b0};
        RECEIVE_SERIAL_OUT <= rsh_r[BW-1]; // R14
        rcnt_r <= rcnt_r + 1'b1;
        if (rbyte_end) rx_busy_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  wire gain_nxt = HIGH_GAIN_IN && !transmit_power_enable; // R9 R19

  // every pin from a flop
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      PORT_BIT_CLOCK <= 1'b0;
      TRANSMIT_READY_OUT <= 1'b0;
      RECEIVE_READY_OUT <= 1'b0;
      CHANNEL_CLEAR_FLAG <= 1'b0;
      AMP_GAIN_SELECT_OUT <= 1'b0;
      AMP_GAIN_SELECT_N <= 1'b1;
      ANTENNA_CHOOSE <= 1'b0;
      ANTENNA_CHOOSE_N <= 1'b1;
      RX_ENABLE <= 1'b0;
      ACQ_RESTART <= 1'b0;
      MOD_RUN <= 1'b0;
      TX_DONE <= 1'b0;
      TX_BYTE_VALID <= 1'b0;
      TX_BYTE <= '0;
      RX_WORD_READY <= 1'b0;
    end else begin
      PORT_BIT_CLOCK <= bclk_r; // R12
      TRANSMIT_READY_OUT <= (st_nxt == bbmdp_pkg::TX_SEND) && tf_in_ready
                            && !tpush_r && !soft_rst; // R10
      RECEIVE_READY_OUT <= rx_busy_r && !soft_rst; // R11
      CHANNEL_CLEAR_FLAG <= rx_on && CHAN_CLEAR_IN && !soft_rst; // R8
      AMP_GAIN_SELECT_OUT <= gain_nxt; // R9
      AMP_GAIN_SELECT_N <= !gain_nxt; // R20
      ANTENNA_CHOOSE <= ANT_ALT_IN; // R16
      ANTENNA_CHOOSE_N <= !ANT_ALT_IN; // R20
      RX_ENABLE <= rx_on && !soft_rst; // R7
      ACQ_RESTART <= rbyte_end && rlast_r && !soft_rst; // R3
      MOD_RUN <= (st_nxt != bbmdp_pkg::TX_IDLE) && !soft_rst; // R2
      TX_DONE <= transmit_power_enable_fall && sending; // R6
      TX_BYTE_VALID <= TX_BYTE_VALID ? !TX_BYTE_READY : tf_out_valid; // held until taken
      TX_BYTE <= tx_load ? tf_out_data : TX_BYTE;
      RX_WORD_READY <= rload_r && !rx_take && rx_on && !soft_rst;
    end
  end
endmodule

// ==== bbmdp_chk.sv ====
`timescale 1ns/10ps
// ****************
// port checker
// ****************
module bbmdp_chk #(
  parameter int RAMP_CYC = 4
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // controller pins
  input wire logic TRANSMIT_POWER_ENABLE_IN,
  input wire logic CHIP_RESET_IN,
  input wire logic TRANSMIT_READY_OUT,
  input wire logic RECEIVE_READY_OUT,
  input wire logic RECEIVE_SERIAL_OUT,
  input wire logic CHANNEL_CLEAR_FLAG,
  input wire logic AMP_GAIN_SELECT_OUT,
  input wire logic AMP_GAIN_SELECT_N,
  input wire logic ANTENNA_CHOOSE,
  input wire logic ANTENNA_CHOOSE_N,
  // modem side
  input wire logic MOD_RUN,
  input wire logic TX_DONE,
  input wire logic RX_WORD_VALID,
  input wire logic RX_WORD_READY,
  input wire bbmdp_pkg::bbmdp_rxw_t RX_WORD,
  input wire logic CHAN_CLEAR_IN,
  input wire logic HIGH_GAIN_IN,
  input wire logic ANT_ALT_IN,
  input wire logic RX_ENABLE
);
  localparam int RHI = RAMP_CYC + 2;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // complementary outputs and copies
  a_pair_inverse: assert property (
    AMP_GAIN_SELECT_N != AMP_GAIN_SELECT_OUT && ANTENNA_CHOOSE_N != ANTENNA_CHOOSE)
    else $error("complement outputs not inverse");
  a_ant_copy: assert property ($past(RST_B) |-> ANTENNA_CHOOSE == $past(ANT_ALT_IN))
    else $error("antenna output not following");
  a_gain_copy: assert property (
    (!TRANSMIT_POWER_ENABLE_IN) [*5] |-> AMP_GAIN_SELECT_OUT == $past(HIGH_GAIN_IN))
    else $error("gain output not following");
  a_gain_tx_low: assert property (TRANSMIT_READY_OUT |-> !AMP_GAIN_SELECT_OUT)
    else $error("gain high during transmit");
  a_tx_priority: assert property (
    TRANSMIT_READY_OUT |-> !RX_ENABLE && !CHANNEL_CLEAR_FLAG)
    else $error("receiver on during transmit");
  a_clear_cause: assert property (CHANNEL_CLEAR_FLAG |-> $past(CHAN_CLEAR_IN))
    else $error("clear flag without cause");
  // transmit tail and receive start
  a_ramp_tail: assert property (
    TX_DONE |=> !TX_DONE && MOD_RUN ##1 MOD_RUN ##[1:RHI] !MOD_RUN)
    else $error("ramp tail wrong");
  a_rx_first_bit: assert property (
    RX_WORD_VALID && RX_WORD_READY |=>
    RECEIVE_SERIAL_OUT == $past(RX_WORD.data[7]) ##1 RECEIVE_READY_OUT)
    else $error("receive start wrong");
  a_chip_clear: assert property (
    CHIP_RESET_IN [*6] |-> !TRANSMIT_READY_OUT && !RECEIVE_READY_OUT && !MOD_RUN)
    else $error("chip reset not clearing");
endmodule
bind bbmdp_port bbmdp_chk #(.RAMP_CYC(RAMP_CYC)) chk (.*);

// ==== bbmdp_mac.sv ====
`timescale 1ns/10ps
// ****************
// controller model
// ****************
module bbmdp_mac (
  // system clock
  input wire logic clk,
  // link from the port
  input wire logic bclk,
  input wire logic rdy,
  // pins to the port
  output logic transmit_power_enable,
  output logic receive_power_enable,
  output logic txd
);
  logic bclk_q = 0;
  logic rdy_q = 0;
  logic rdy_qq = 0; // ready as the port saw it when it sampled the bit
  logic [7:0] sh = '0;
  int n = -1;
  logic [7:0] txq[$];
  initial begin
    transmit_power_enable = 0;
    receive_power_enable = 0;
    txd = 0;
  end
  // one bit moves on each accepted bit clock rise
  always @(posedge clk) begin
    bclk_q <= bclk;
    rdy_q <= rdy;
    rdy_qq <= rdy_q;
    if (n < 0) begin
      txd <= ~txd; // idle: never a stale bit
    end else begin
      txd <= sh[7];
      if (bclk && !bclk_q && rdy_qq && n > 0) begin
        sh <= sh << 1;
        n <= n - 1;
      end
    end
  end
  // one packet, msb first, enable dropped at the end
  task automatic frame(input int cnt);
    transmit_power_enable <= 1;
    repeat (cnt) begin
      sh = txq.pop_front();
      n = 8;
      wait (n == 0);
    end
    repeat (40) @(posedge clk);
    transmit_power_enable <= 0;
    n = -1;
  endtask
  // set both power enables
  task automatic pe(input logic t, input logic r);
    transmit_power_enable <= t;
    receive_power_enable <= r;
  endtask
endmodule

// ==== baseband_mac_data_port_bench.sv ====
`timescale 1ns/10ps
// ****************
// port bench
// ****************
module baseband_mac_data_port_bench;
  logic CLK_SYS = 0;
  logic RST_B = 0;
  logic CHIP_RESET_IN = 0;
  logic TX_BYTE_READY = 0;
  logic RX_WORD_VALID = 0;
  logic CHAN_CLEAR_IN = 0;
  logic HIGH_GAIN_IN = 0;
  logic ANT_ALT_IN = 0;
  bbmdp_pkg::bbmdp_rxw_t RX_WORD = '0;
  logic TRANSMIT_POWER_ENABLE_IN, RECEIVE_POWER_ENABLE_IN, TRANSMIT_SERIAL_IN, PORT_BIT_CLOCK;
  logic TRANSMIT_READY_OUT, RECEIVE_READY_OUT, RECEIVE_SERIAL_OUT, CHANNEL_CLEAR_FLAG;
  logic AMP_GAIN_SELECT_OUT, AMP_GAIN_SELECT_N, ANTENNA_CHOOSE, ANTENNA_CHOOSE_N;
  logic TX_BYTE_VALID, MOD_RUN, TX_DONE, RX_WORD_READY, RX_ENABLE, ACQ_RESTART;
  logic [bbmdp_pkg::BYTE_W-1:0] TX_BYTE;
  int errors = 0;
  int checks = 0;
  int seed = 32'h7d5b;
  int dones = 0;
  int acqs = 0;
  int k;
  logic stall = 1;
  logic [7:0] b;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];
  bbmdp_port #(.RAMP_CYC(4)) dut (.*);
  bbmdp_mac mac (.clk(CLK_SYS), .bclk(PORT_BIT_CLOCK), .rdy(TRANSMIT_READY_OUT),
    .transmit_power_enable(TRANSMIT_POWER_ENABLE_IN), .receive_power_enable(RECEIVE_POWER_ENABLE_IN), .txd(TRANSMIT_SERIAL_IN));
  // clock
  always #4 CLK_SYS = ~CLK_SYS;
  // random modem inputs, byte and pulse collection
  always @(posedge CLK_SYS) begin
    {HIGH_GAIN_IN, ANT_ALT_IN, CHAN_CLEAR_IN} <= 3'($random(seed));
    TX_BYTE_READY <= !stall && 1'($random(seed));
    if (TX_BYTE_VALID && TX_BYTE_READY) got_q.push_back(TX_BYTE);
    if (TX_DONE === 1'b1) dones++;
    if (ACQ_RESTART === 1'b1) acqs++;
  end
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // offer one word, read its bits at bit clock rises
  task automatic rx_word(input logic [7:0] d, input logic l);
    logic [7:0] s;
    RX_WORD_VALID <= 1;
    RX_WORD <= {l, d};
    k = 0;
    do begin @(posedge CLK_SYS); k++; end while (RX_WORD_READY !== 1'b1 && k < 500);
    check("rx word taken", RX_WORD_READY, 1);
    RX_WORD_VALID <= 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge PORT_BIT_CLOCK);
      s = {s[6:0], RECEIVE_SERIAL_OUT};
      if (i == 0) check("rx ready", RECEIVE_READY_OUT, 1);
    end
    check("rx byte", s, d);
  endtask
  // verdict
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge CLK_SYS);
    RST_B <= 1;
    repeat (4) @(posedge CLK_SYS);
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? 8'h81 : 8'($random(seed));
      exp_q.push_back(b);
      mac.txq.push_back(b);
    end
    fork
      mac.frame(6);
    join_none
    repeat (100) @(posedge CLK_SYS);
    check("tx ready", TRANSMIT_READY_OUT, 1);
    repeat (900) @(posedge CLK_SYS);
    check("tx ready full", TRANSMIT_READY_OUT, 0);
    stall <= 0;
    k = 0;
    while (mac.n >= 0 && k < 3000) begin @(posedge CLK_SYS); k++; end
    check("tx frame end", 8'(mac.n < 0), 1);
    repeat (20) @(posedge CLK_SYS);
    check("tx count", 8'(got_q.size()), 6);
    for (int i = 0; i < 6; i++) check("tx byte", got_q[i], exp_q[i]);
    check("tx done", 8'(dones), 1);
    check("mod run", MOD_RUN, 0);
    $display("transmit test done");
    mac.pe(0, 1);
    repeat (10) @(posedge CLK_SYS);
    check("rx enable", RX_ENABLE, 1);
    for (int i = 0; i < 3; i++) rx_word((i == 0) ? 8'hff : 8'($random(seed)), i == 2);
    repeat (40) @(posedge CLK_SYS);
    check("acq restart", 8'(acqs), 1);
    $display("receive test done");
    mac.pe(1, 1);
    repeat (10) @(posedge CLK_SYS);
    check("rx enable prio", RX_ENABLE, 0);
    check("gain in tx", AMP_GAIN_SELECT_OUT, 0);
    check("tx ready prio", TRANSMIT_READY_OUT, 1);
    CHIP_RESET_IN <= 1;
    repeat (10) @(posedge CLK_SYS);
    check("tx ready reset", TRANSMIT_READY_OUT, 0);
    check("mod run reset", MOD_RUN, 0);
    CHIP_RESET_IN <= 0;
    mac.pe(0, 0);
    repeat (20) @(posedge CLK_SYS);
    $display("priority and reset test done");
    summarize();
  end
  // hang guard
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule
